// file: hw/ext_bus_pkg.sv
// shared constants and carrier types for the external memory bus block
package ext_bus_pkg;
  localparam logic [7:0]  PORT_RESET      = 8'hff;
  localparam logic [7:0]  LOW_FILL        = 8'hff;
  localparam logic [15:0] LIMIT_8K        = 16'h1fff;
  localparam logic [15:0] LIMIT_16K       = 16'h3fff;
  localparam logic [15:0] LIMIT_32K       = 16'h7fff;
  localparam logic [1:0]  VARIANT_8K      = 2'h0;
  localparam logic [1:0]  VARIANT_16K     = 2'h1;
  localparam logic [1:0]  VARIANT_32K     = 2'h2;
  localparam int          RD_STROBE_BIT   = 7;
  localparam int          WR_STROBE_BIT   = 6;
  localparam logic [1:0]  KIND_FETCH      = 2'h0;
  localparam logic [1:0]  KIND_READ       = 2'h1;
  localparam logic [1:0]  KIND_WRITE      = 2'h2;

  typedef struct packed {
    logic [1:0]  kind;
    logic        wide;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } req_type;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_LATCH = 3'b010,
    ST_SETUP = 3'b011,
    ST_STROB = 3'b100,
    ST_HOLD  = 3'b101
  } state_type;
endpackage

// file: hw/external_memory_bus.sv
// external program and data memory bus sequencer with port latch handling
// Function
// - code fetches use program_fetch_strobe as their only read strobe.
// - data reads and writes strobe via port three bits 7 and 6.
// - fetches use 16-bit address; data uses 16-bit pointer or 8-bit index form.
// - 16-bit access drives upper byte on high_port, strongly, whole cycle.
// - high_port latch untouched by address output, reappears after access.
// - 8-bit access keeps high_port latch on pins for paging.
// - low_port multiplexes address low and data, both drivers active.
// - low address byte valid at falling edge of address_latch_strobe.
// - write data on low_port before store strobe, held after release.
// - read byte captured just before data_read_strobe releases.
// - any external access loads all ones into the low_port latch.
// - software low_port writes ignored while any external access is running.
// - fetch externally if external_access_select or pc above variant limit.
// - external execution drives all high_port bits with pc upper byte only during each fetch access.
`timescale 1ns/1ns
`default_nettype none
module external_memory_bus (
  input  wire logic                 clk,            // core clock, 250 MHz
  input  wire logic                 rst,            // synchronous reset, high
  input  wire logic                 ce,             // clock enable, freezes all state
  input  wire logic                 ext_access_n,   // external_access_select, active low
  input  wire logic [1:0]           variant,        // internal program size selector
  input  wire logic                 req_valid,      // core access request
  input  wire ext_bus_pkg::req_type req,            // request fields
  output logic                      req_ready,      // block idle, request taken
  output logic                      done,           // one-cycle pulse, access over
  output logic [7:0]                rdata,          // byte captured from low_port
  output logic                      fetch_external, // pc fetch must go external
  input  wire logic                 low_wr,         // software write to low_port latch
  input  wire logic [7:0]           low_wdata,      // software data for low_port latch
  input  wire logic                 high_wr,        // software write to high_port latch
  input  wire logic [7:0]           high_wdata,     // software data for high_port latch
  input  wire logic                 p3_latch_rd,    // port three bit 7 latch value
  input  wire logic                 p3_latch_wr,    // port three bit 6 latch value
  output logic [7:0]                low_latch,      // low_port latch value
  output logic [7:0]                high_latch,     // high_port latch value
  input  wire logic [7:0]           low_in,         // low_port pin levels
  output logic [7:0]                low_out,        // low_port output value
  output logic [7:0]                low_oe_n,       // low_port enables, low drives
  output logic [7:0]                high_out,       // high_port pin value
  output logic                      high_strong,    // high_port strong pullups for ones
  output logic                      address_latch_strobe, // address latch strobe, high
  output logic                      program_fetch_strobe_n, // program fetch strobe, low
  output logic                      data_read_strobe_n,  // port three bit 7 pin
  output logic                      data_store_strobe_n  // port three bit 6 pin
);
  ext_bus_pkg::state_type state_ff;
  ext_bus_pkg::state_type nxt_state;
  ext_bus_pkg::req_type   cur_ff;
  logic                   ready_ff;
  logic [7:0]             low_latch_ff;
  logic [7:0]             high_latch_ff;
  logic [7:0]             rdata_ff;
  logic                   done_ff;
  logic                   fetch_ext_ff;
  logic [7:0]             low_out_ff;
  logic [7:0]             low_oe_n_ff;
  logic [7:0]             high_out_ff;
  logic                   strong_ff;
  logic                   addr_strb_ff;
  logic                   fetch_strb_n_ff;
  logic                   rd_strb_n_ff;
  logic                   wr_strb_n_ff;

  // request side and the access in progress
  wire                       busy      = state_ff != ext_bus_pkg::ST_IDLE;
  wire                       start     = req_valid && !busy;
  wire ext_bus_pkg::req_type nxt_cur   = start ? req : cur_ff;
  wire                       is_fetch  = cur_ff.kind == ext_bus_pkg::KIND_FETCH;
  wire                       is_read   = cur_ff.kind == ext_bus_pkg::KIND_READ;
  wire                       is_write  = cur_ff.kind == ext_bus_pkg::KIND_WRITE;
  wire                       in_strobe = state_ff == ext_bus_pkg::ST_STROB;
  wire                       to_strobe = state_ff == ext_bus_pkg::ST_SETUP;

  // variant 3 treated as the largest internal size
  wire [15:0] limit  = (variant == ext_bus_pkg::VARIANT_8K)  ? ext_bus_pkg::LIMIT_8K  :
                       (variant == ext_bus_pkg::VARIANT_16K) ? ext_bus_pkg::LIMIT_16K :
                                                               ext_bus_pkg::LIMIT_32K;
  wire        go_ext = !ext_access_n || (req.addr > limit);

  // address, latch strobe fall, setup, strobe, hold
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ext_bus_pkg::ST_IDLE:  nxt_state = start ? ext_bus_pkg::ST_ADDR : ext_bus_pkg::ST_IDLE;
      ext_bus_pkg::ST_ADDR:  nxt_state = ext_bus_pkg::ST_LATCH;
      ext_bus_pkg::ST_LATCH: nxt_state = ext_bus_pkg::ST_SETUP;
      ext_bus_pkg::ST_SETUP: nxt_state = ext_bus_pkg::ST_STROB;
      ext_bus_pkg::ST_STROB: nxt_state = ext_bus_pkg::ST_HOLD;
      ext_bus_pkg::ST_HOLD:  nxt_state = ext_bus_pkg::ST_IDLE;
      default:               nxt_state = ext_bus_pkg::ST_IDLE;
    endcase
  end

  // bus access owns the low latch; software writes during it are dropped
  wire [7:0] nxt_low_latch  = (start || busy) ? ext_bus_pkg::LOW_FILL :
                              low_wr ? low_wdata : low_latch_ff;
  wire [7:0] nxt_high_latch = high_wr ? high_wdata : high_latch_ff;
  wire       nxt_ready      = nxt_state == ext_bus_pkg::ST_IDLE;
  wire       nxt_done       = state_ff == ext_bus_pkg::ST_HOLD;
  wire [7:0] nxt_rdata      = (in_strobe && !is_write) ? low_in : rdata_ff;

  // pins are computed for the coming cycle so that each one is a flop
  wire       nxt_fetch    = nxt_cur.kind == ext_bus_pkg::KIND_FETCH;
  wire       nxt_write    = nxt_cur.kind == ext_bus_pkg::KIND_WRITE;
  wire       nxt_wide     = nxt_fetch || nxt_cur.wide;
  wire       nxt_active   = nxt_state != ext_bus_pkg::ST_IDLE;
  wire       nxt_addr_ph  = nxt_state == ext_bus_pkg::ST_ADDR || nxt_state == ext_bus_pkg::ST_LATCH;
  wire       nxt_data_ph  = nxt_write && (nxt_state == ext_bus_pkg::ST_SETUP ||
                            nxt_state == ext_bus_pkg::ST_STROB || nxt_state == ext_bus_pkg::ST_HOLD);
  wire       nxt_drive    = nxt_addr_ph || nxt_data_ph;
  // address stands one cycle before and one after the latch strobe falls
  wire [7:0] nxt_low_out  = nxt_data_ph ? nxt_cur.wdata :
                            nxt_drive   ? nxt_cur.addr[7:0] : low_latch_ff;
  // outside bus mode a latch one floats the pin, so reads see the memory
  wire [7:0] nxt_low_oe_n = nxt_drive ? 8'h00 : low_latch_ff;
  wire [7:0] nxt_high_out = (nxt_active && nxt_wide) ? nxt_cur.addr[15:8] :
                                                       nxt_high_latch;
  wire       nxt_strong   = nxt_active && nxt_wide;
  wire       nxt_fetch_n  = !(to_strobe && is_fetch);
  wire       nxt_rd_n     = (to_strobe && is_read) ? 1'b0 : p3_latch_rd;
  wire       nxt_wr_n     = (to_strobe && is_write) ? 1'b0 : p3_latch_wr;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= ext_bus_pkg::ST_IDLE;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ready_ff <= 1'b1;
    end else if (ce) begin
      ready_ff <= nxt_ready;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur_ff <= '0;
    end else if (ce) begin
      cur_ff <= nxt_cur;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      low_latch_ff <= ext_bus_pkg::PORT_RESET;
    end else if (ce) begin
      low_latch_ff <= nxt_low_latch;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      high_latch_ff <= ext_bus_pkg::PORT_RESET;
    end else if (ce) begin
      high_latch_ff <= nxt_high_latch;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else if (ce) begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      done_ff <= 1'b0;
    end else if (ce) begin
      done_ff <= nxt_done;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fetch_ext_ff <= 1'b0;
    end else if (ce) begin
      fetch_ext_ff <= go_ext;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      low_out_ff <= ext_bus_pkg::PORT_RESET;
    end else if (ce) begin
      low_out_ff <= nxt_low_out;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      low_oe_n_ff <= 8'hff;
    end else if (ce) begin
      low_oe_n_ff <= nxt_low_oe_n;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      high_out_ff <= ext_bus_pkg::PORT_RESET;
    end else if (ce) begin
      high_out_ff <= nxt_high_out;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      strong_ff <= 1'b0;
    end else if (ce) begin
      strong_ff <= nxt_strong;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      addr_strb_ff <= 1'b0;
    end else if (ce) begin
      addr_strb_ff <= start;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fetch_strb_n_ff <= 1'b1;
    end else if (ce) begin
      fetch_strb_n_ff <= nxt_fetch_n;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_strb_n_ff <= 1'b1;
    end else if (ce) begin
      rd_strb_n_ff <= nxt_rd_n;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_strb_n_ff <= 1'b1;
    end else if (ce) begin
      wr_strb_n_ff <= nxt_wr_n;
    end
  end

  assign req_ready              = ready_ff;
  assign done                   = done_ff;
  assign rdata                  = rdata_ff;
  assign fetch_external         = fetch_ext_ff;
  assign low_latch              = low_latch_ff;
  assign high_latch             = high_latch_ff;
  assign low_out                = low_out_ff;
  assign low_oe_n               = low_oe_n_ff;
  assign high_out               = high_out_ff;
  assign high_strong            = strong_ff;
  assign address_latch_strobe   = addr_strb_ff;
  assign program_fetch_strobe_n = fetch_strb_n_ff;
  assign data_read_strobe_n     = rd_strb_n_ff;
  assign data_store_strobe_n    = wr_strb_n_ff;
endmodule
`default_nettype wire

// file: verification/ext_mem_model.sv
// partner model: external memory behind an address latch on the low port
`timescale 1ns/1ns
`default_nettype none
module ext_mem_model (
  input  wire logic       clk,   // core clock
  input  wire logic       ale,   // address latch strobe, high
  input  wire logic       rd_n,  // fetch or read strobe, low
  input  wire logic       wr_n,  // store strobe, low
  input  wire logic [7:0] bus,   // low_port value from the block
  output logic [7:0]      din    // what the memory puts on low_port
);
  logic [7:0] mem [256];
  logic [7:0] adr_lo = 8'h00;
  logic [7:0] last   = 8'h00;
  logic       ale_q  = 1'b0;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h3c;
  // released bus shows the inverse of the last value, never a stale copy
  always @* din = rd_n ? ~last : mem[adr_lo];
  always @(posedge clk) begin
    ale_q <= ale;
    last  <= din;
    if (ale_q && !ale) adr_lo <= bus;
    if (!wr_n) mem[adr_lo] <= bus;
  end
endmodule
`default_nettype wire

// file: verification/external_memory_bus_chk.sv
// concurrent checks on the external memory bus block ports
`timescale 1ns/1ns
`default_nettype none
module external_memory_bus_chk (
  input wire logic                 clk,                    // core clock
  input wire logic                 rst,                    // sync reset
  input wire logic                 ce,                     // clock enable
  input wire logic                 ext_access_n,           // external select, low
  input wire logic                 req_valid,              // request
  input wire ext_bus_pkg::req_type req,                    // request fields
  input wire logic                 req_ready,              // idle
  input wire logic                 done,                   // access over
  input wire logic                 fetch_external,         // fetch goes external
  input wire logic [7:0]           low_latch,              // low latch
  input wire logic [7:0]           high_latch,             // high latch
  input wire logic [7:0]           low_out,                // low_port value
  input wire logic [7:0]           low_oe_n,               // low_port enables
  input wire logic [7:0]           high_out,               // high_port value
  input wire logic                 high_strong,            // strong pullups
  input wire logic                 address_latch_strobe,   // latch strobe
  input wire logic                 program_fetch_strobe_n, // fetch strobe
  input wire logic                 data_read_strobe_n,     // read strobe
  input wire logic                 data_store_strobe_n     // store strobe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire logic take;
  wire logic fetch;
  assign take  = ce && req_valid && req_ready;
  assign fetch = req.kind == ext_bus_pkg::KIND_FETCH;
  property p_ale; take |=> address_latch_strobe ##1 !address_latch_strobe; endproperty
  a_ale: assert property (p_ale) else $error("latch strobe pulse wrong");
  property p_adr; take |=> ##1 low_out == $past(req.addr[7:0], 2) && low_oe_n == 8'h00; endproperty
  a_adr: assert property (p_adr) else $error("low address not valid at strobe fall");
  property p_fet; take && fetch |=> ##3 !program_fetch_strobe_n && data_read_strobe_n && data_store_strobe_n;
  endproperty
  a_fet: assert property (p_fet) else $error("fetch strobe wrong");
  property p_rd; take && req.kind == ext_bus_pkg::KIND_READ |=> ##3 !data_read_strobe_n && program_fetch_strobe_n;
  endproperty
  a_rd: assert property (p_rd) else $error("read strobe wrong");
  property p_wr; take && req.kind == ext_bus_pkg::KIND_WRITE |=> ##2 low_out == $past(req.wdata, 3)
    ##1 !data_store_strobe_n ##1 data_store_strobe_n && low_out == $past(req.wdata, 5); endproperty
  a_wr: assert property (p_wr) else $error("write data not around store strobe");
  property p_h16; take && (req.wide || fetch) |=> high_out == $past(req.addr[15:8]) && high_strong
    ##1 $stable(high_out) [*3]; endproperty
  a_h16: assert property (p_h16) else $error("upper address not held");
  property p_h8; take && !req.wide && !fetch |=> (high_out == high_latch) [*5]; endproperty
  a_h8: assert property (p_h8) else $error("high latch not on pins");
  property p_fill; take |=> ##5 done && low_latch == 8'hff; endproperty
  a_fill: assert property (p_fill) else $error("low latch not filled");
  property p_back; done |-> high_out == high_latch; endproperty
  a_back: assert property (p_back) else $error("high latch not restored");
  property p_sel; !ext_access_n |=> fetch_external; endproperty
  a_sel: assert property (p_sel) else $error("select ignored");
  c_fet: cover property (take && fetch);
  c_wr: cover property (take && req.kind == ext_bus_pkg::KIND_WRITE);
  c_rd: cover property (take && req.kind == ext_bus_pkg::KIND_READ && !req.wide);
endmodule
bind external_memory_bus external_memory_bus_chk i_chk (.clk, .rst, .ce, .ext_access_n, .req_valid, .req,
  .req_ready, .done, .fetch_external, .low_latch, .high_latch, .low_out, .low_oe_n, .high_out, .high_strong,
  .address_latch_strobe, .program_fetch_strobe_n, .data_read_strobe_n, .data_store_strobe_n);
`default_nettype wire

// file: verification/testbench.sv
// self-checking bench for the external memory bus block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk = 1'b0, rst = 1'b1, ext_access_n = 1'b1, req_valid = 1'b0, low_wr = 1'b0, high_wr = 1'b0;
  logic [1:0] variant = 2'h0;
  ext_bus_pkg::req_type req = '0;
  logic [7:0] low_wdata = 8'h00, high_wdata = 8'h00, rdata, low_latch, high_latch, low_in, low_out, low_oe_n;
  logic [7:0] high_out, mdin;
  logic req_ready, done, fetch_external, high_strong, address_latch_strobe, program_fetch_strobe_n;
  logic data_read_strobe_n, data_store_strobe_n;
  int errors = 0, checked = 0;
  always #2 clk = ~clk;
  assign low_in = (~low_oe_n & low_out) | (low_oe_n & mdin);
  external_memory_bus i_external_memory_bus (.clk, .rst, .ce(1'b1), .ext_access_n, .variant, .req_valid, .req,
    .req_ready, .done, .rdata, .fetch_external, .low_wr, .low_wdata, .high_wr, .high_wdata, .p3_latch_rd(1'b1),
    .p3_latch_wr(1'b1), .low_latch, .high_latch, .low_in, .low_out, .low_oe_n, .high_out, .high_strong,
    .address_latch_strobe, .program_fetch_strobe_n, .data_read_strobe_n, .data_store_strobe_n);
  ext_mem_model i_ext_mem_model (.clk, .ale(address_latch_strobe), .rd_n(program_fetch_strobe_n & data_read_strobe_n),
    .wr_n(data_store_strobe_n), .bus(low_out), .din(mdin));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic step; @(posedge clk); #1; endtask
  // poke keeps software writes to the low latch going through the whole access
  task automatic access(input logic [1:0] k, input logic w, input logic [15:0] a, input logic [7:0] d, input logic poke);
    int n;
    int m;
    step;
    req = '{k, w, a, d};
    req_valid = 1'b1;
    for (n = 0; n < 20 && req_ready !== 1'b1; n++) step;
    step;
    req_valid = 1'b0;
    for (m = 0; m < 20 && done !== 1'b1; m++) begin
      low_wr = poke;
      low_wdata = 8'h11;
      if (done !== 1'b1) step;
    end
    low_wr = 1'b0;
    if (n == 20 || m == 20) begin
      errors++;
      conclude;
    end
  endtask
  task automatic s_write_read;
    access(ext_bus_pkg::KIND_WRITE, 1'b1, 16'h12a5, 8'h6b, 1'b0);
    access(ext_bus_pkg::KIND_READ, 1'b0, 16'h00a5, 8'h00, 1'b0);
    chk(16'(rdata), 16'h006b);
  endtask
  task automatic s_fetch;
    step;
    high_wr = 1'b1;
    high_wdata = 8'h3c;
    low_wr = 1'b1;
    low_wdata = 8'h5a;
    step;
    high_wr = 1'b0;
    low_wr = 1'b0;
    step;
    chk(16'(low_latch), 16'h005a);
    chk(16'(low_oe_n), 16'h005a);
    access(ext_bus_pkg::KIND_FETCH, 1'b0, 16'hbe42, 8'h00, 1'b1);
    chk(16'(rdata), 16'h007e);
    chk(16'(low_latch), 16'h00ff);
    chk(16'(low_oe_n), 16'h00ff);
    chk(16'(high_latch), 16'h003c);
    chk(16'(high_out), 16'h003c);
  endtask
  task automatic s_ext;
    logic [15:0] lim;
    for (int v = 0; v < 4; v++) begin
      variant = 2'(v);
      lim = (v == 0) ? 16'h1fff : (v == 1) ? 16'h3fff : 16'h7fff;
      for (int o = 0; o < 2; o++) begin
        req.addr = lim + 16'(o);
        step;
        step;
        chk(16'(fetch_external), 16'(o));
      end
    end
    ext_access_n = 1'b0;
    req.addr = 16'h0000;
    step;
    step;
    chk(16'(fetch_external), 16'h0001);
    ext_access_n = 1'b1;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    s_write_read;
    s_fetch;
    s_ext;
    conclude;
  end
endmodule
`default_nettype wire
